/* File: core/switch_cfg_pkg.sv */
package switch_cfg_pkg;
  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int          FRAME_BITS   = 16;         // serial word length
  localparam int          WD_POS       = 15;         // watchdog toggle bit
  localparam int          ADDR_HI      = 14;         // address field top
  localparam int          ADDR_LO      = 10;         // address field bottom
  localparam int          SEL_HI       = 14;         // output select top
  localparam int          SEL_LO       = 13;         // output select bottom
  localparam int          NM_POS       = 9;          // normal mode flag in reply
  localparam int          DATA_W       = 9;          // config payload width
  // ************************************************************
  // register codes (low three address bits, global is full code)
  // ************************************************************
  localparam logic [2:0]  CODE_STATUS  = 3'h0;       // status select
  localparam logic [2:0]  CODE_FAULT   = 3'h3;       // output_fault_management
  localparam logic [2:0]  CODE_OCUR    = 3'h4;       // output_overcurrent_profile
  localparam logic [4:0]  ADDR_GLOBAL  = 5'h05;      // global_configuration
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int          FM_W         = 7;          // fault mgmt bits D6:D0
  localparam int          FM_UNLIM     = 6;          // retry counter unlimited
  localparam int          FM_RDIS      = 5;          // retry disable
  localparam int          FM_OS        = 4;          // supply short protect disable
  localparam int          FM_OLON      = 3;          // on open-load disable
  localparam int          FM_OLOFF     = 2;          // off open-load disable
  localparam int          FM_LED       = 1;          // led open-load threshold
  localparam int          FM_RATIO     = 0;          // sense ratio high
  localparam int          OC_GAS       = 8;          // gas-discharge profile
  localparam int          OC_COOL_LO   = 6;          // cooling curve D7:D6
  localparam int          OC_INR_LO    = 4;          // inrush curve D5:D4
  localparam int          OC_ALT       = 3;          // alt high threshold
  localparam int          OC_STDY_LO   = 1;          // steady limit D2:D1
  localparam int          OC_MODE      = 0;          // overcurrent mode
  localparam int          GC_VFAIL     = 8;          // supply fail detector en
  localparam int          GC_PWM       = 7;          // pwm module enable
  localparam int          GC_CLK       = 6;          // pwm clock internal
  localparam int          GC_TEMP      = 5;          // temperature report
  localparam int          GC_MIRR      = 4;          // current mirror en
  localparam int          GC_MSEL_LO   = 2;          // mirror output select D3:D2
  localparam int          GC_OVDIS     = 0;          // overvoltage protect disable
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] RST_WORD     = 16'h0000;   // register reset value
endpackage

/* File: core/switch_cfg_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - D6 unlimited retry, D5 disables retry
// - D4 disables supply-short protection
// - D3 disables on open-load; D1 picks LED
// - D2 disables off-state open-load detection
// - D0 picks high sense ratio
// - per-output writes go to D14:D13 output
// - D8 selects gas-discharge lamp profile
// - D7:D6 select cooling curve speed
// - D5:D4 select inrush curve speed
// - D3 uses second high threshold early
// - D2:D1 pick steady-state current limit
// - D0 adds bulb cooling management
// - global D8 enables supply-fail fail-safe
// - global D7 enables PWM, ignores inputs
// - global D6 picks internal PWM clock
// - global D5:D2 choose analog feedback
// - global D0 disables overvoltage protection
// - select low loads reply, MSB first
// - bits past sixteen echo input delayed
// - latch only whole multiples of sixteen
// - status selection persists until rewritten
// - invalid frame ignored; low supply does not block frames, only gates fail_safe
// - reply carries watchdog, selection, normal flag
// - frame holds watchdog, address, zero, data
module switch_cfg_regs #(
  parameter int N_OUT = 4                          // number of switch outputs
) (
  input  wire logic               clk_sys,         // system clock
  input  wire logic               rst_n,           // sync reset, active low
  input  wire logic               clk_en,          // freezes system state when low
  input  wire logic               serial_clk,      // link clock from controller
  input  wire logic               chip_select_n,   // frame select, active low
  input  wire logic               serial_in,       // serial data in
  output logic                    serial_out,      // serial data out
  output logic                    serial_out_oe,   // serial out drive enable
  input  wire logic [N_OUT*8-1:0] fault_status,    // fault byte per output
  input  wire logic               normal_mode,     // device in normal mode
  input  wire logic               logic_supply_low, // logic supply below fail level
  output logic [N_OUT-1:0]        retry_unlimited, // retry counter unlimited
  output logic [N_OUT-1:0]        retry_enable,    // autoretry enabled
  output logic [N_OUT-1:0]        supply_short_protect_en, // short-to-supply guard
  output logic [N_OUT-1:0]        on_openload_bulb, // on open-load, bulb level
  output logic [N_OUT-1:0]        on_openload_led, // on open-load, led level
  output logic [N_OUT-1:0]        off_openload_en, // off open-load enabled
  output logic [N_OUT-1:0]        sense_ratio_high, // high sense ratio
  output logic [N_OUT-1:0]        gas_lamp_profile, // gas-discharge profile
  output logic [N_OUT*2-1:0]      cooling_curve,   // cooling speed code
  output logic [N_OUT*2-1:0]      inrush_curve,    // inrush speed code
  output logic [N_OUT-1:0]        alt_high_threshold_sel, // second high level
  output logic [N_OUT*2-1:0]      steady_limit_sel, // steady limit code
  output logic [N_OUT-1:0]        overcurrent_mode_sel, // inrush plus cooling
  output logic                    fail_safe,       // supply-fail fail-safe active
  output logic                    pwm_module_en,   // outputs follow pwm regs
  output logic                    pwm_clk_internal, // pwm uses internal osc
  output logic                    pwm_clk_external, // pwm uses first_direct_input
  output logic                    current_mirror_en, // feedback mirrors current
  output logic                    temp_report_en,  // feedback reports temperature
  output logic                    feedback_tristate, // feedback pin off
  output logic [1:0]              mirror_output_sel, // mirrored output
  output logic                    overvoltage_protect_en // ov protection on
);
  // ************************************************************
  // link domain: shift in, count, shift out
  // ************************************************************
  logic [15:0] in_shift_reg;   // last sixteen input bits
  logic [3:0]  bit_cnt_reg;    // bits mod sixteen
  logic        any_bit_reg;    // at least one clock seen
  logic        past16_reg;     // at least sixteen bits clocked
  logic        fresh_reg;      // no edge yet in this frame
  logic        so_reg;         // output bit on falling edge
  logic [15:0] tx_word_reg;    // reply word, stable while selected

  // fresh flag: set by deselect, cleared by first edge
  always_ff @(posedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // input shift and bit counter; kept after frame for the system side
  always_ff @(posedge serial_clk) begin
    in_shift_reg <= {in_shift_reg[14:0], serial_in};
    if (fresh_reg) begin
      bit_cnt_reg <= 4'h1;
      any_bit_reg <= 1'b1;
      past16_reg  <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == 4'hf) begin
        past16_reg <= 1'b1;
      end
    end
  end

  // after sixteen bits the echoed input follows
  always_ff @(negedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      so_reg <= 1'b0;
    end else if (past16_reg || bit_cnt_reg == 4'h0) begin
      so_reg <= in_shift_reg[15];
    end else begin
      so_reg <= tx_word_reg[4'hf - bit_cnt_reg];
    end
  end

  // the flag is preset by the select pin itself, so no stale bit leads
  // first bit is out before any clock edge
  assign serial_out = fresh_reg ? tx_word_reg[15] : so_reg;

  // ************************************************************
  // system domain: crossing and frame acceptance
  // ************************************************************
  logic cs_s1_reg;     // first sync stage
  logic cs_s2_reg;     // second sync stage
  logic cs_prev_reg;   // for edge detect
  logic vlow_s1_reg;   // supply-low sync stage 1
  logic vlow_s2_reg;   // supply-low sync stage 2
  logic cs_rise;       // frame ended
  logic frame_ok;      // length is a whole multiple of sixteen
  logic [2:0] code;    // low address bits
  logic [1:0] sel;     // output select of frame
  logic wr_fm;         // write fault management
  logic wr_oc;         // write overcurrent profile
  logic wr_gc;         // write global config
  logic wr_st;         // write status select

  // two-flop synchronisers for the pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_prev_reg <= 1'b1;
      vlow_s1_reg <= 1'b0;
      vlow_s2_reg <= 1'b0;
    end else if (clk_en) begin
      cs_s1_reg   <= chip_select_n;
      cs_s2_reg   <= cs_s1_reg;
      cs_prev_reg <= cs_s2_reg;
      vlow_s1_reg <= logic_supply_low;
      vlow_s2_reg <= vlow_s1_reg;
    end
  end

  // link regs are quiet once select is high, so reading them here is safe
  assign cs_rise  = clk_en && cs_s2_reg && !cs_prev_reg;
  // limitation: a select pulse with no clocks reuses the last count, which
  // repeats the last frame's write: no change unless that frame fell in a freeze or a reset followed it
  // only whole multiples of sixteen are latched
  assign frame_ok = any_bit_reg && bit_cnt_reg == 4'h0;
  assign code  = in_shift_reg[switch_cfg_pkg::ADDR_LO+2:switch_cfg_pkg::ADDR_LO];
  assign sel   = in_shift_reg[switch_cfg_pkg::SEL_HI:switch_cfg_pkg::SEL_LO];
  assign wr_fm = cs_rise && frame_ok && code == switch_cfg_pkg::CODE_FAULT;
  assign wr_oc = cs_rise && frame_ok && code == switch_cfg_pkg::CODE_OCUR;
  assign wr_st = cs_rise && frame_ok && code == switch_cfg_pkg::CODE_STATUS;
  assign wr_gc = cs_rise && frame_ok && in_shift_reg[switch_cfg_pkg::ADDR_HI:
                 switch_cfg_pkg::ADDR_LO] == switch_cfg_pkg::ADDR_GLOBAL;

  // serial out drives only while selected
  assign serial_out_oe = !cs_s2_reg;

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [6:0] fm_reg [N_OUT];  // fault management per output
  logic [8:0] oc_reg [N_OUT];  // overcurrent profile per output
  logic [8:0] gc_reg;          // global configuration
  logic [4:0] ret_sel_reg;     // status select contents
  logic       last_wd_reg;     // watchdog of last frame
  logic [4:0] last_addr_reg;   // address of last frame

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      // only the addressed output takes the write
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          fm_reg[g] <= switch_cfg_pkg::RST_WORD[6:0];
          oc_reg[g] <= switch_cfg_pkg::RST_WORD[8:0];
        end else begin
          if (wr_fm && sel == 2'(g)) begin
            fm_reg[g] <= in_shift_reg[6:0];
          end
          if (wr_oc && sel == 2'(g)) begin
            oc_reg[g] <= in_shift_reg[8:0];
          end
        end
      end

      assign retry_unlimited[g] = fm_reg[g][switch_cfg_pkg::FM_UNLIM];
      assign retry_enable[g]    = !fm_reg[g][switch_cfg_pkg::FM_RDIS];

      assign supply_short_protect_en[g] = !fm_reg[g][switch_cfg_pkg::FM_OS];

      assign on_openload_bulb[g] = !fm_reg[g][switch_cfg_pkg::FM_OLON] &&
                                   !fm_reg[g][switch_cfg_pkg::FM_LED];
      assign on_openload_led[g]  = !fm_reg[g][switch_cfg_pkg::FM_OLON] &&
                                   fm_reg[g][switch_cfg_pkg::FM_LED];

      assign off_openload_en[g]  = !fm_reg[g][switch_cfg_pkg::FM_OLOFF];

      assign sense_ratio_high[g] = fm_reg[g][switch_cfg_pkg::FM_RATIO];

      assign gas_lamp_profile[g] = oc_reg[g][switch_cfg_pkg::OC_GAS];

      assign cooling_curve[2*g+:2] = oc_reg[g][switch_cfg_pkg::OC_COOL_LO+:2];

      assign inrush_curve[2*g+:2]  = oc_reg[g][switch_cfg_pkg::OC_INR_LO+:2];

      assign alt_high_threshold_sel[g] = oc_reg[g][switch_cfg_pkg::OC_ALT];

      assign steady_limit_sel[2*g+:2] = oc_reg[g][switch_cfg_pkg::OC_STDY_LO+:2];

      assign overcurrent_mode_sel[g] = oc_reg[g][switch_cfg_pkg::OC_MODE];
    end
  endgenerate

  // global register, status select and last-frame echo fields
  // a bad-length frame changes nothing at all
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gc_reg        <= switch_cfg_pkg::RST_WORD[8:0];
      ret_sel_reg   <= switch_cfg_pkg::RST_WORD[4:0];
      last_wd_reg   <= 1'b0;
      last_addr_reg <= 5'h00;
    end else begin
      if (wr_gc) begin
        gc_reg <= in_shift_reg[8:0];
      end
      // selection held until next status-select write
      if (wr_st) begin
        ret_sel_reg <= in_shift_reg[4:0];
      end
      if (cs_rise && frame_ok) begin
        last_wd_reg   <= in_shift_reg[switch_cfg_pkg::WD_POS];
        last_addr_reg <= in_shift_reg[switch_cfg_pkg::ADDR_HI:switch_cfg_pkg::ADDR_LO];
      end
    end
  end

  assign fail_safe         = gc_reg[switch_cfg_pkg::GC_VFAIL] && vlow_s2_reg;

  assign pwm_module_en     = gc_reg[switch_cfg_pkg::GC_PWM];

  assign pwm_clk_internal  = pwm_module_en && gc_reg[switch_cfg_pkg::GC_CLK];
  assign pwm_clk_external  = pwm_module_en && !gc_reg[switch_cfg_pkg::GC_CLK];

  assign current_mirror_en = gc_reg[switch_cfg_pkg::GC_MIRR];
  assign temp_report_en    = gc_reg[switch_cfg_pkg::GC_TEMP] && !current_mirror_en;
  assign feedback_tristate = !gc_reg[switch_cfg_pkg::GC_TEMP] && !current_mirror_en;
  assign mirror_output_sel = gc_reg[switch_cfg_pkg::GC_MSEL_LO+:2];

  assign overvoltage_protect_en = !gc_reg[switch_cfg_pkg::GC_OVDIS];

  // ************************************************************
  // reply word
  // ************************************************************
  // selected content for reply bits 8:0
  function automatic logic [8:0] reply_data(input logic [4:0] rs);
    logic [1:0] o;
    o = rs[4:3];
    case (rs[2:0])
      switch_cfg_pkg::CODE_STATUS: reply_data = {1'b0, fault_status[8*o+:8]};
      switch_cfg_pkg::CODE_FAULT:  reply_data = {2'b00, fm_reg[o]};
      switch_cfg_pkg::CODE_OCUR:   reply_data = oc_reg[o];
      3'h5:                        reply_data = (o == 2'b00) ? gc_reg : 9'h000;
      default:                     reply_data = 9'h000;
    endcase
  endfunction

  // refreshing every enabled idle cycle keeps fault status live for the next frame
  // reply updated only while deselected, frozen during a frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_word_reg <= switch_cfg_pkg::RST_WORD;
    end else if (clk_en && cs_s2_reg) begin
      tx_word_reg <= {last_wd_reg, last_addr_reg, normal_mode,
                      reply_data(ret_sel_reg)};
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_fm_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_fm |=> fm_reg[$past(sel)] == $past(in_shift_reg[6:0]))
    else $error("fault management write lost");

  a_sel_isolate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_fm && sel != 2'b00) |=> $stable(fm_reg[0]))
    else $error("unselected output changed");

  a_oc_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_oc |=> oc_reg[$past(sel)] == $past(in_shift_reg[8:0]))
    else $error("overcurrent write lost");

  a_gc_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_gc |=> pwm_module_en == $past(in_shift_reg[7]))
    else $error("global write lost");

  a_bad_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && !frame_ok) |=> $stable(gc_reg) && $stable(ret_sel_reg))
    else $error("invalid frame latched");

  a_led_thresh: assert property (@(posedge clk_sys) disable iff (!rst_n)
    on_openload_led[0] |-> !fm_reg[0][3] && fm_reg[0][1] && !on_openload_bulb[0])
    else $error("open-load mode wrong");

  a_pwm_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwm_clk_external |-> gc_reg[7] && !gc_reg[6] && !pwm_clk_internal)
    else $error("pwm clock select wrong");

  a_feedback_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot({current_mirror_en, temp_report_en, feedback_tristate}))
    else $error("feedback modes overlap");

  a_sel_persist: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !wr_st |=> $stable(ret_sel_reg))
    else $error("status selection drifted");

  a_reply_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cs_s2_reg) |=> tx_word_reg[9] == $past(normal_mode))
    else $error("normal flag not in reply");

  // a deselect seen on the system side with a whole word behind it
  sequence s_word_done;
    cs_rise && frame_ok;
  endsequence

  // that word, then one enabled idle cycle that refreshes the reply
  sequence s_echo_ready;
    s_word_done ##1 (clk_en && cs_s2_reg);
  endsequence

  // status selection taken straight from the frame
  a_st_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_st |=> ret_sel_reg == $past(in_shift_reg[4:0]))
    else $error("status selection write lost");

  // echo fields capture the accepted frame
  a_echo_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_word_done |=> last_addr_reg == $past(in_shift_reg[14:10]) &&
      last_wd_reg == $past(in_shift_reg[15]))
    else $error("echo fields not captured");

  // reply carries the echoed address one cycle after capture
  a_reply_echo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_echo_ready |=> tx_word_reg[14:10] == $past(last_addr_reg))
    else $error("echo address not in reply");
endmodule

/* File: dv/spi_master_model.sv */
`timescale 1ns/1ps
// ************************************************************
// serial controller model
// ************************************************************
module spi_master_model (
  output logic      serial_clk,    // link clock, still between frames
  output logic      chip_select_n, // frame select, active low
  output logic      serial_in,     // data toward the device
  input  wire logic serial_out     // reply from the device
);
  // idle: deselected, clock low
  initial begin
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
    // a late rising select presets the device's first-bit flag
    #1;
    chip_select_n = 1'b1;
  end
  // frame length chosen
  // the caller picks n, so a bad length can still be sent on purpose
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    #3.3;
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      #7.5;
      serial_clk = 1'b1;
      rx = {rx[30:0], serial_out};
      #7.5;
      serial_clk = 1'b0;
    end
    #7.5;
    chip_select_n = 1'b1;
    // released line shows the inverse so a stale bit is never read as valid
    serial_in = ~serial_in;
  endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
// ************************************************************
// testbench for the configuration and status registers
// ************************************************************
module tb_top;
  logic        clk_sys, rst_n, clk_en, normal_mode, logic_supply_low;   // system side
  logic        serial_clk, chip_select_n, serial_in, serial_out, serial_out_oe; // link
  logic [31:0] fault_status;                                            // fault bytes
  logic [3:0]  retry_unlimited, retry_enable, supply_short_protect_en, on_openload_bulb;
  logic [3:0]  on_openload_led, off_openload_en, sense_ratio_high, gas_lamp_profile;
  logic [3:0]  alt_high_threshold_sel, overcurrent_mode_sel;            // per output
  logic [7:0]  cooling_curve, inrush_curve, steady_limit_sel;           // two-bit codes
  logic        fail_safe, pwm_module_en, pwm_clk_internal, pwm_clk_external;
  logic        current_mirror_en, temp_report_en, feedback_tristate, overvoltage_protect_en;
  logic [1:0]  mirror_output_sel;                                       // mirrored output
  int          err_count, comparisons;                                  // tallies
  logic [6:0]  fm [4];                                                  // shadow fault mgmt
  logic [8:0]  oc [4];                                                  // shadow overcurrent
  logic [8:0]  gc;                                                      // shadow global
  logic [15:0] last;                                                    // last valid frame
  logic [2:0]  ss_code;                                                 // returned content
  logic [1:0]  ss_sel;                                                  // returned output
  logic [31:0] rx_frozen;                                               // reply while frozen

  switch_cfg_regs switch_cfg_regs_inst (.clk_sys, .rst_n, .clk_en, .serial_clk,
    .chip_select_n, .serial_in, .serial_out, .serial_out_oe, .fault_status, .normal_mode,
    .logic_supply_low, .retry_unlimited, .retry_enable, .supply_short_protect_en,
    .on_openload_bulb, .on_openload_led, .off_openload_en, .sense_ratio_high,
    .gas_lamp_profile, .cooling_curve, .inrush_curve, .alt_high_threshold_sel,
    .steady_limit_sel, .overcurrent_mode_sel, .fail_safe, .pwm_module_en,
    .pwm_clk_internal, .pwm_clk_external, .current_mirror_en, .temp_report_en,
    .feedback_tristate, .mirror_output_sel, .overvoltage_protect_en);
  spi_master_model spi_master_model_inst (.serial_clk, .chip_select_n, .serial_in,
    .serial_out);

  // system clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // one compare, counted
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // content the last status select asks for
  function automatic logic [8:0] content();
    case (ss_code)
      switch_cfg_pkg::CODE_STATUS: return {1'b0, fault_status[ss_sel*8 +: 8]};
      switch_cfg_pkg::CODE_FAULT:  return {2'b00, fm[ss_sel]};
      switch_cfg_pkg::CODE_OCUR:   return oc[ss_sel];
      3'h5:                        return (ss_sel == 2'h0) ? gc : 9'h000;
      default:                     return 9'h000;
    endcase
  endfunction
  // every decoded level against the shadow registers
  task automatic check_outs();
    for (int g = 0; g < 4; g++) begin
      chk("per_output", 32'({retry_unlimited[g], retry_enable[g], supply_short_protect_en[g],
        on_openload_bulb[g], on_openload_led[g], off_openload_en[g], sense_ratio_high[g],
        gas_lamp_profile[g], cooling_curve[2*g +: 2], inrush_curve[2*g +: 2],
        alt_high_threshold_sel[g], steady_limit_sel[2*g +: 2], overcurrent_mode_sel[g]}),
        32'({fm[g][6], ~fm[g][5], ~fm[g][4], ~fm[g][3] & ~fm[g][1], ~fm[g][3] & fm[g][1],
        ~fm[g][2], fm[g][0], oc[g][8], oc[g][7:6], oc[g][5:4], oc[g][3], oc[g][2:1],
        oc[g][0]}));
    end
    chk("global", 32'({fail_safe, pwm_module_en, pwm_clk_internal, pwm_clk_external,
      current_mirror_en, temp_report_en, feedback_tristate, mirror_output_sel,
      overvoltage_protect_en}), 32'({gc[8] & logic_supply_low, gc[7], gc[7] & gc[6],
      gc[7] & ~gc[6], gc[4], gc[5] & ~gc[4], ~gc[5] & ~gc[4], gc[3:2], ~gc[0]}));
  endtask
  // one frame: reply and echo checked, shadow updated only for whole words
  task automatic wr(input int n, input logic [1:0] sel, input logic [2:0] code,
                    input logic [8:0] data, input logic [15:0] hi);
    logic [15:0] f;
    logic [31:0] rx, exp;
    f   = {~last[15], sel, code, 1'b0, data};
    exp = (32'({last[15:10], normal_mode, content()}) << (n - 16)) | 32'(hi);
    spi_master_model_inst.xfer(n, {hi, f}, rx);
    chk("reply", rx, exp);
    if (n % 16 == 0) begin
      last = f;
      if (code == switch_cfg_pkg::CODE_STATUS) begin
        ss_code = data[2:0];
        ss_sel  = data[4:3];
      end
      if (code == switch_cfg_pkg::CODE_FAULT) fm[sel] = data[6:0];
      if (code == switch_cfg_pkg::CODE_OCUR) oc[sel] = data;
      if ({sel, code} == switch_cfg_pkg::ADDR_GLOBAL) gc = data;
    end
    repeat (10) @(negedge clk_sys);
    chk("so_enable", 32'(serial_out_oe), 32'h0000_0000);
    check_outs();
  endtask
  // counts, verdict, stop
  task automatic end_of_test();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the few microseconds the frames need
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  // main sequence; codes: 0 status select, 3 fault mgmt, 4 overcurrent, 5 global
  initial begin
    {rst_n, clk_en, normal_mode, logic_supply_low} = 4'h7;
    fault_status = 32'h5a3c_81e7;
    {err_count, comparisons, last, gc, ss_code, ss_sel} = '0;
    for (int g = 0; g < 4; g++) begin
      fm[g] = '0;
      oc[g] = '0;
    end
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check_outs();
    wr(16, 2'h2, 3'h3, 9'h07f, 16'h0000);   // fault settings reach output two only
    wr(16, 2'h0, 3'h3, 9'h002, 16'h0000);   // led open-load threshold, output zero
    wr(16, 2'h1, 3'h4, 9'h1a9, 16'h0000);   // overcurrent profile, output one
    wr(16, 2'h0, 3'h5, 9'h1d5, 16'h0000);   // global: fail detector, mirror, ov off
    logic_supply_low = 1'b0;                // fail detector on, supply fine
    wr(16, 2'h3, 3'h5, 9'h0ff, 16'h0000);   // select bits nonzero: not global
    wr(16, 2'h0, 3'h5, 9'h0e0, 16'h0000);   // internal pwm clock, temperature
    wr(16, 2'h0, 3'h5, 9'h080, 16'h0000);   // external pwm clock
    wr(16, 2'h2, 3'h0, 9'h013, 16'h0000);   // return fault settings of output two
    wr(16, 2'h1, 3'h4, 9'h056, 16'h0000);   // selection persists over other writes
    wr(24, 2'h0, 3'h3, 9'h00a, 16'h00c5);   // bad length: nothing latched
    wr(32, 2'h3, 3'h3, 9'h035, 16'hbeef);   // daisy chain, last word latched
    wr(16, 2'h3, 3'h0, 9'h01c, 16'h0000);   // return overcurrent of output three
    wr(16, 2'h0, 3'h0, 9'h005, 16'h0000);   // return global
    normal_mode = 1'b0;
    repeat (4) @(negedge clk_sys);
    wr(16, 2'h1, 3'h0, 9'h008, 16'h0000);   // return fault byte of output one
    wr(16, 2'h0, 3'h7, 9'h1ff, 16'h0000);   // unmapped address, only echo fields
    clk_en = 1'b0;                          // a frame wholly inside a freeze
    spi_master_model_inst.xfer(16, 32'({~last[15], 5'h05, 1'b0, 9'h101}), rx_frozen);
    chk("frozen_reply", rx_frozen, 32'({last[15:10], normal_mode, content()}));
    repeat (10) @(negedge clk_sys);
    clk_en = 1'b1;
    repeat (10) @(negedge clk_sys);
    check_outs();                           // frozen frame left no trace
    wr(16, 2'h0, 3'h0, 9'h000, 16'h0000);
    end_of_test();
  end
endmodule
